/* File: design/latched_piso_shift_register.sv */
// Purpose: Eight-stage parallel-in serial-out shift register behind an input latch
// Assumes: All pins asynchronous to CLK_I; strobes slower than the pin filter
// Notes: Bit 0 is stage A and input A; bit 7 is stage H and input H
//
// Functional notes
// [R01] Eight-bit input latch feeds eight shift stages A to H in parallel.
// [R02] Latch strobe rising edge captures parallel inputs; other strobe activity does nothing.
// [R03] Mode high: shift strobe rising edge moves serial input into stage A.
// [R04] Mode low: serial input ignored, no serial shifting on shift strobe.
// [R05] Mode low, out of reset: stages follow latch contents continuously.
// [R06] Each shift: A takes serial input, each stage feeds next, H discarded.
// [R07] Serial output always shows stage H.
// [R08] Reset pin low clears stages and serial output at once; latch kept.
// [R09] During reset, latch strobe still loads latch; stages stay cleared.
// [R10] Mode low, latch strobe edge: new data reaches stages and output.
// [R11] Mode high, both strobes rising together: latch loads and one shift.
// [R12] Mode high, no strobe edges: latch and stages hold.
// [R13] Host resets or transfers before trusting the serial output.
`include "piso_params.svh"

module latched_piso_shift_register #(
  parameter int STAGES = `PISO_STAGES
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SHIFT_RESET_N_I,
  input wire logic MODE_SERIAL_I,
  input wire logic LATCH_STROBE_I,
  input wire logic SHIFT_STROBE_I,
  input wire logic SERIAL_IN_I,
  input wire logic [STAGES-1:0] PARALLEL_IN_I,
  output logic SERIAL_OUT_O
);

  generate
    if (STAGES != `PISO_STAGES)
    begin : g_bad_stages
      $error("latched_piso_shift_register supports eight stages only");
    end
  endgenerate

  logic clear_async;
  logic reset_n_lvl;
  logic mode_lvl;
  logic latch_lvl;
  logic shift_lvl;
  logic serial_in_lvl;
  logic [STAGES-1:0] parallel_lvl;
  logic latch_rise;
  logic shift_rise;
  piso_pkg::shift_mode_e mode;

  logic [STAGES-1:0] input_latch_contents_ff;
  logic [STAGES-1:0] nxt_input_latch_contents;
  logic [STAGES-1:0] shift_stage_contents_ff;
  logic [STAGES-1:0] nxt_shift_stage_contents;
  logic [STAGES-1:0] latch_view;

  // Pin low clears the stages without waiting for a clock edge
  assign clear_async = RST_I | ~SHIFT_RESET_N_I; // [R08]

  pin_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_reset (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(SHIFT_RESET_N_I),
    .level_o(reset_n_lvl)
  );

  pin_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_sync_ctrl (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i({MODE_SERIAL_I, LATCH_STROBE_I, SHIFT_STROBE_I, SERIAL_IN_I}),
    .level_o({mode_lvl, latch_lvl, shift_lvl, serial_in_lvl})
  );

  // Data passes the same depth as the strobes so it lines up with the edge
  pin_sync #(.WIDTH(STAGES), .RST_VAL(`PISO_LATCH_RST)) u_sync_data (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pin_i(PARALLEL_IN_I),
    .level_o(parallel_lvl)
  );

  rise_detect u_latch_edge (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .level_i(latch_lvl),
    .rise_o(latch_rise)
  );

  rise_detect u_shift_edge (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .level_i(shift_lvl),
    .rise_o(shift_rise)
  );

  assign mode = piso_pkg::decode_mode(mode_lvl);

  // Input latch: loads on rising strobe only, whatever the reset pin does
  always_comb
  begin
    nxt_input_latch_contents = input_latch_contents_ff; // [R12]
    if (latch_rise)
    begin
      nxt_input_latch_contents = parallel_lvl; // [R02] [R09] [R11]
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      input_latch_contents_ff <= `PISO_LATCH_RST;
    end
    else
    begin
      input_latch_contents_ff <= nxt_input_latch_contents; // [R01]
    end
  end

  // Value the latch shows this cycle, new data included
  assign latch_view = latch_rise ? parallel_lvl : input_latch_contents_ff; // [R10]

  always_comb
  begin
    nxt_shift_stage_contents = shift_stage_contents_ff; // [R12]
    if (!reset_n_lvl)
    begin
      // Held clear until the released reset has passed the filter
      nxt_shift_stage_contents = `PISO_STAGE_RST; // [R09]
    end
    else
    begin
      case (mode)
        piso_pkg::MODE_PARALLEL:
        begin
          nxt_shift_stage_contents = latch_view; // [R04] [R05] [R10] [R01]
        end
        piso_pkg::MODE_SERIAL:
        begin
          if (shift_rise)
          begin
            nxt_shift_stage_contents =
              {shift_stage_contents_ff[STAGES-2:0], serial_in_lvl}; // [R03] [R06] [R11]
          end
        end
        default:
        begin
          nxt_shift_stage_contents = shift_stage_contents_ff;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge clear_async)
  begin
    if (clear_async)
    begin
      shift_stage_contents_ff <= `PISO_STAGE_RST; // [R08]
    end
    else
    begin
      shift_stage_contents_ff <= nxt_shift_stage_contents;
    end
  end

  // Stage H flop drives the pin directly
  assign SERIAL_OUT_O = shift_stage_contents_ff[`PISO_STAGE_H]; // [R07]

endmodule : latched_piso_shift_register

/* File: include/piso_params.svh */
// Purpose: Constants of the latched parallel-in serial-out shift register
// Assumes: Included by its bare name
// Notes: Widths, reset values and pin filter depth
`ifndef PISO_PARAMS_SVH
`define PISO_PARAMS_SVH

`define PISO_STAGES 8
`define PISO_LATCH_RST 8'h00
`define PISO_STAGE_RST 8'h00
`define PISO_SYNC_FLOPS 3
`define PISO_STAGE_A 0
`define PISO_STAGE_H 7

`endif

/* File: include/piso_pkg.sv */
// Purpose: Types of the latched parallel-in serial-out shift register
// Assumes: Nothing
// Notes: Mode select decoded by function
package piso_pkg;

  typedef enum logic {MODE_PARALLEL, MODE_SERIAL} shift_mode_e;

  function automatic shift_mode_e decode_mode(input logic level);
    decode_mode = level ? MODE_SERIAL : MODE_PARALLEL;
  endfunction : decode_mode

endpackage : piso_pkg

/* File: design/pin_sync.sv */
// Purpose: Three-flop pin synchroniser with agreement filter
// Assumes: One clock, asynchronous active-high reset
// Notes: A bit changes once the second and third flops agree
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] sync3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("pin_sync needs WIDTH of at least 1");
    end
  endgenerate

  always_comb
  begin
    // Per bit: take the new value only where both late flops agree
    nxt_level = (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (level_ff & (sync2_ff ^ sync3_ff));
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_ff <= RST_VAL;
      sync2_ff <= RST_VAL;
      sync3_ff <= RST_VAL;
      level_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= pin_i;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;

endmodule : pin_sync

/* File: design/rise_detect.sv */
// Purpose: One-cycle pulse on a low-to-high change of a filtered level
// Assumes: Level already in the clock domain
// Notes: Pulse is combinational from the held previous value
module rise_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic rise_o
);

  logic prev_ff;
  logic nxt_prev;

  always_comb
  begin
    nxt_prev = level_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= nxt_prev;
    end
  end

  assign rise_o = level_i & ~prev_ff;

endmodule : rise_detect

/* File: dv/piso_chk.sv */
// Purpose: Port checker for the latched shift register
// Assumes: About five clocks from pin to output
// Notes: Bound at the foot
module piso_chk #(
  parameter int STAGES = 8
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SHIFT_RESET_N_I,
  input wire logic MODE_SERIAL_I,
  input wire logic LATCH_STROBE_I,
  input wire logic SHIFT_STROBE_I,
  input wire logic SERIAL_IN_I,
  input wire logic [STAGES-1:0] PARALLEL_IN_I,
  input wire logic SERIAL_OUT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lat_q_ff;
  logic lat_h_ff;
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  // Expected latch bit H
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      lat_q_ff <= 1'b0;
      lat_h_ff <= 1'b0;
    end
    else
    begin
      lat_q_ff <= LATCH_STROBE_I;
      if (LATCH_STROBE_I && !lat_q_ff)
      begin
        lat_h_ff <= PARALLEL_IN_I[STAGES-1];
      end
    end
  end
  sequence s_xfer;
    $rose(LATCH_STROBE_I) ##0 (!MODE_SERIAL_I && SHIFT_RESET_N_I)[*7];
  endsequence
  sequence s_low;
    (!MODE_SERIAL_I && !LATCH_STROBE_I && SHIFT_RESET_N_I)[*8];
  endsequence
  AST_RST_CLR: assert property (!SHIFT_RESET_N_I |-> !SERIAL_OUT_O)
    else $error("output not cleared");
  AST_XFER: assert property (s_xfer |-> SERIAL_OUT_O == PARALLEL_IN_I[STAGES-1])
    else $error("transfer wrong");
  AST_LOW_HOLD: assert property (s_low |-> $stable(SERIAL_OUT_O))
    else $error("output moved in parallel mode");
  AST_LOW_FOLLOW: assert property (s_low |-> SERIAL_OUT_O == lat_h_ff)
    else $error("output not latch bit");
  AST_HI_HOLD: assert property
    ((MODE_SERIAL_I && !SHIFT_STROBE_I && SHIFT_RESET_N_I)[*8] |-> $stable(SERIAL_OUT_O))
    else $error("output moved while idle");
  AST_RST_REL: assert property ($rose(SHIFT_RESET_N_I) |-> !SERIAL_OUT_O[*3])
    else $error("clear not held");
  AST_STANDS: assert property ($changed(SERIAL_OUT_O) ##1 SHIFT_RESET_N_I[*3]
    |-> SERIAL_OUT_O == $past(SERIAL_OUT_O, 3)) else $error("output not held");
  AST_SHIFT: assert property ((MODE_SERIAL_I && SHIFT_RESET_N_I)[*8] ##0
    $changed(SERIAL_OUT_O) |-> $past(SHIFT_STROBE_I, 5) && !$past(SHIFT_STROBE_I, 8))
    else $error("change without shift");
endmodule : piso_chk

bind latched_piso_shift_register piso_chk #(.STAGES(STAGES)) chk_u (
  .CLK_I(CLK_I), .RST_I(RST_I), .SHIFT_RESET_N_I(SHIFT_RESET_N_I),
  .MODE_SERIAL_I(MODE_SERIAL_I), .LATCH_STROBE_I(LATCH_STROBE_I),
  .SHIFT_STROBE_I(SHIFT_STROBE_I), .SERIAL_IN_I(SERIAL_IN_I),
  .PARALLEL_IN_I(PARALLEL_IN_I), .SERIAL_OUT_O(SERIAL_OUT_O));

/* File: dv/host_rx.sv */
// Purpose: Host side collecting the serial output
// Assumes: Output settled when take is high
// Notes: First bit ends on top
module host_rx (
  input wire logic clk_i,
  input wire logic take_i,
  input wire logic bit_i,
  output logic [7:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i)
    if (take_i) word_o <= {word_o[6:0], bit_i};
endmodule : host_rx

/* File: dv/tb.sv */
// Purpose: Testbench of the latched shift register
// Assumes: Pins held long past the filter
// Notes: Host model gathers shifted words
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, shift_rst_n = 1, mode = 0, lat = 0, sh = 0, sin = 0, take = 0;
  logic sout;
  logic [7:0] pin = 8'h00;
  logic [7:0] word;
  int n_errors = 0, compares = 0, cyc = 0;
  latched_piso_shift_register dut_u (.CLK_I(clk), .RST_I(rst), .SHIFT_RESET_N_I(shift_rst_n),
    .MODE_SERIAL_I(mode), .LATCH_STROBE_I(lat), .SHIFT_STROBE_I(sh), .SERIAL_IN_I(sin),
    .PARALLEL_IN_I(pin), .SERIAL_OUT_O(sout));
  host_rx host_u (.clk_i(clk), .take_i(take), .bit_i(sout), .word_o(word));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task strobe(input logic l, input logic s);
    repeat (4) @(posedge clk);
    lat <= l;
    sh <= s;
    repeat (4) @(posedge clk);
    lat <= 1'b0;
    sh <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : strobe
  task pin_rst(input logic v);
    @(posedge clk);
    shift_rst_n <= v;
    #1;
  endtask : pin_rst
  task grab();
    @(posedge clk);
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    @(posedge clk);
  endtask : grab
  task t_reset();
    pin_rst(1'b0);
    chk(8'(sout), 8'h00);
    @(posedge clk);
    pin <= 8'h80;
    strobe(1'b1, 1'b0);
    chk(8'(sout), 8'h00);
    pin_rst(1'b1);
    repeat (8) @(posedge clk);
    chk(8'(sout), 8'h01);
    pin_rst(1'b0);
    chk(8'(sout), 8'h00);
    repeat (8) @(posedge clk);
    pin_rst(1'b1);
    repeat (8) @(posedge clk);
    chk(8'(sout), 8'h01);
  endtask : t_reset
  task t_xfer();
    pin <= 8'h34;
    strobe(1'b1, 1'b0);
    chk(8'(sout), 8'h00);
    pin <= 8'hb4;
    strobe(1'b1, 1'b0);
    chk(8'(sout), 8'h01);
    sin <= 1'b1;
    strobe(1'b0, 1'b1);
    chk(8'(sout), 8'h01);
  endtask : t_xfer
  task t_shift();
    logic [7:0] pat;
    pat = 8'hcb;
    mode <= 1'b1;
    pin <= 8'h5a;
    grab();
    for (int i = 0; i < 15; i++)
    begin
      sin <= (i < 8) ? pat[7 - i] : 1'b0;
      strobe(i == 0, 1'b1);
      grab();
      if (i == 6) chk(word, 8'hb4);
    end
    chk(word, pat);
    repeat (12) @(posedge clk);
    mode <= 1'b0;
    repeat (10) @(posedge clk);
    chk(8'(sout), 8'h00);
  endtask : t_shift
  task finish_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_xfer();
    t_shift();
    finish_test();
  end
endmodule : tb
